// ==== hw/sos_regs.svh ====
/*
 * Constants of the operating-state sequencer: clock rate, boot and escalation
 * timing, reset values of the pin and control outputs.
 * Assumes a single 50 MHz system clock; included by bare name.
 */
`ifndef SOS_REGS_SVH
`define SOS_REGS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SOS_CLK_MHZ 50
`define SOS_COLD_BOOT_NS 10000
`define SOS_COLD_BOOT_CYC ((`SOS_COLD_BOOT_NS * `SOS_CLK_MHZ + 999) / 1000)
`define SOS_NMI_WAIT_NS 200000
`define SOS_NMI_WAIT_CYC ((`SOS_NMI_WAIT_NS * `SOS_CLK_MHZ + 999) / 1000)
`define SOS_WARM_PULSE_NS 1000
`define SOS_WARM_PULSE_CYC ((`SOS_WARM_PULSE_NS * `SOS_CLK_MHZ + 999) / 1000)

// ****************************************
// Reset values
// ****************************************
`define SOS_PIN_IDLE 1'b1
`define SOS_MEM_SECURE_RST 1'b1
`define SOS_ACT_OFF_RST 1'b1

`endif

// ==== hw/sos_pkg.sv ====
/*
 * Types of the operating-state sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sos_pkg;

    // Operating states, Gray coded along the boot path
    typedef enum logic [2:0] {
        SOS_RESET = 3'b000,
        SOS_COLD = 3'b001,
        SOS_WARM = 3'b011,
        SOS_PREOP = 3'b010,
        SOS_OPER = 3'b110,
        SOS_SAFE = 3'b111
    } sos_state_t;

endpackage

// ==== hw/sos_sync.sv ====
/*
 * Two-stage synchroniser for pin inputs.
 * Assumes d is asynchronous to clk; only stage two is read outside.
 */
`timescale 1ns/1ps
module sos_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [WIDTH-1:0] d, // Asynchronous input
    output logic [WIDTH-1:0] q // Synchronised output
);

    logic [WIDTH-1:0] meta_q;

    // Two flops in a row
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// ==== hw/sos_timer.sv ====
/*
 * Run-length timer: done is high while run has lasted CYCLES cycles.
 * Assumes run is from the clk domain; dropping run restarts the count.
 */
`timescale 1ns/1ps
module sos_timer #(
    parameter int CYCLES = 16
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic run, // Count while high
    output logic done // Count reached
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_q;

    if (CYCLES < 1) begin : g_chk
        $error("sos_timer: CYCLES must be at least 1");
    end

    assign done = run && (cnt_q == LAST);

    // Saturating counter, cleared when idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != LAST) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

endmodule

// ==== hw/sos_sequencer.sv ====
/*
 * Operating-state sequencer and fault-response grading of the device.
 * Assumes fault, boot and acknowledge inputs come from logic on clk; the
 * warm reset pin is open drain, read back through a synchroniser.
 */
`timescale 1ns/1ps
`include "sos_regs.svh"
module sos_sequencer #(
    parameter int NMI_WAIT_CYC = `SOS_NMI_WAIT_CYC,
    parameter int COLD_CYC = `SOS_COLD_BOOT_CYC,
    parameter int PULSE_CYC = `SOS_WARM_PULSE_CYC
) (
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst_b, // Power-on reset, active low
    input wire logic warmResetPinIn, // Level seen on the warm reset pin
    output logic warmResetPinOut, // Value driven on the pin (always low)
    output logic warmResetPinOe, // High while pulling the pin low
    input wire logic faultIrq, // Fault wanting a CPU interrupt
    input wire logic faultNmi, // Level 2 fault: NMI and error status
    input wire logic faultCpuRst, // Fault wanting a CPU reset
    input wire logic faultWarmRst, // Fault wanting the warm reset pin
    input wire logic faultPowerDown, // Fault wanting external power-down
    input wire logic nmiAck, // CPU has serviced the NMI
    input wire logic errClear, // Software clears the error latch
    input wire logic secRelax, // Warm boot loosens memory security
    input wire logic bootDone, // Boot code hands over to customer code
    input wire logic selfTestPass, // Boot-time self-test passed
    input wire logic selfTestFail, // Boot-time self-test failed
    output sos_pkg::sos_state_t opState, // Current operating state
    output logic cpuResetN, // CPU reset, active low
    output logic coldInit, // Analog, control and debug init strobe
    output logic bootFromRom, // CPU fetches from boot ROM
    output logic memSecure, // All memories secured
    output logic cpuIrq, // CPU interrupt
    output logic cpuNmi, // Non-maskable interrupt pending
    output logic errorStatusOut, // Error-status pin, active high
    output logic actuatorOff, // Mission outputs forced inactive
    output logic powerDownReq // Ask supervisor to remove power
);
    import sos_pkg::*;

    // ****************************************
    // Checks and declarations
    // ****************************************
    if (NMI_WAIT_CYC < 2 || COLD_CYC < 1 || PULSE_CYC < 3) begin : g_chk
        $error("sos_sequencer: timing parameters too small");
    end

    sos_state_t state_q, state_d;
    logic pinSync;
    logic coldDone, nmiDone, pulseDone;
    logic resetReq, warmRstReq, enterWarm;
    logic cpuResetN_q, coldInit_q, bootFromRom_q, memSecure_q, memSecure_d;
    logic cpuIrq_q, cpuNmi_q, cpuNmi_d, errStatus_q, errStatus_d;
    logic actOff_q, pwrDown_q, pinOe_q, pinOe_d, pinOut_q;

    // ****************************************
    // Pin input and timers
    // ****************************************
    sos_sync #(
        .WIDTH(1),
        .RST_VAL(`SOS_PIN_IDLE)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(warmResetPinIn),
        .q(pinSync)
    );

    sos_timer #(.CYCLES(COLD_CYC)) u_cold_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .run(state_q == SOS_COLD),
        .done(coldDone)
    );

    sos_timer #(.CYCLES(NMI_WAIT_CYC)) u_nmi_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .run(cpuNmi_q && !pinOe_q),
        .done(nmiDone)
    );

    sos_timer #(.CYCLES(PULSE_CYC)) u_pulse_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .run(pinOe_q),
        .done(pulseDone)
    );

    // ****************************************
    // Fault grading and state decode
    // ****************************************
    // Pin low (outside or our own pulse) or CPU reset fault means reset
    assign resetReq = !pinSync || faultCpuRst;
    // Warm reset pin on request or on an NMI left unserviced
    assign warmRstReq = faultWarmRst || nmiDone;
    assign enterWarm = (state_d == SOS_WARM) && (state_q != SOS_WARM);

    // Next operating state
    always_comb begin
        state_d = state_q;
        if (resetReq) begin
            state_d = SOS_RESET;
        end else begin
            unique case (state_q)
                SOS_RESET: state_d = SOS_COLD;
                SOS_COLD: if (coldDone) state_d = SOS_WARM;
                SOS_WARM: if (bootDone) state_d = SOS_PREOP;
                SOS_PREOP: begin
                    if (selfTestFail || faultNmi) begin
                        state_d = SOS_SAFE;
                    end else if (selfTestPass) begin
                        state_d = SOS_OPER;
                    end
                end
                SOS_OPER: if (faultNmi) state_d = SOS_SAFE;
                SOS_SAFE: state_d = SOS_SAFE;
                default: state_d = SOS_RESET;
            endcase
        end
    end

    // Escalating responses: irq, nmi+error, cpu reset, warm pin, power
    // Pending NMI dies with the CPU reset, or it would re-escalate forever
    assign cpuNmi_d = faultNmi || (cpuNmi_q && !nmiAck && (state_q != SOS_RESET));
    assign errStatus_d = faultNmi || selfTestFail || (errStatus_q && !errClear);
    assign pinOe_d = warmRstReq || (pinOe_q && !pulseDone);
    assign memSecure_d = enterWarm || (state_d == SOS_RESET) || (state_d == SOS_COLD)
        || (memSecure_q && !(secRelax && state_q == SOS_WARM));

    // ****************************************
    // Registers
    // ****************************************
    // Operating state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SOS_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Boot-phase outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuResetN_q <= 1'b0;
            coldInit_q <= 1'b0;
            bootFromRom_q <= 1'b0;
            memSecure_q <= `SOS_MEM_SECURE_RST;
        end else begin
            cpuResetN_q <= (state_d != SOS_RESET) && (state_d != SOS_COLD);
            coldInit_q <= (state_d == SOS_COLD);
            bootFromRom_q <= (state_d == SOS_WARM);
            memSecure_q <= memSecure_d;
        end
    end

    // Fault responses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuIrq_q <= 1'b0;
            cpuNmi_q <= 1'b0;
            errStatus_q <= 1'b0;
            actOff_q <= `SOS_ACT_OFF_RST;
            pwrDown_q <= 1'b0;
            pinOe_q <= 1'b0;
            pinOut_q <= 1'b0;
        end else begin
            cpuIrq_q <= faultIrq;
            cpuNmi_q <= cpuNmi_d;
            errStatus_q <= errStatus_d;
            actOff_q <= errStatus_d || (state_d != SOS_OPER);
            pwrDown_q <= pwrDown_q || faultPowerDown;
            pinOe_q <= pinOe_d;
            pinOut_q <= 1'b0;
        end
    end

    // Outputs straight from flops
    assign opState = state_q;
    assign cpuResetN = cpuResetN_q;
    assign coldInit = coldInit_q;
    assign bootFromRom = bootFromRom_q;
    assign memSecure = memSecure_q;
    assign cpuIrq = cpuIrq_q;
    assign cpuNmi = cpuNmi_q;
    assign errorStatusOut = errStatus_q;
    assign actuatorOff = actOff_q;
    assign powerDownReq = pwrDown_q;
    assign warmResetPinOe = pinOe_q;
    assign warmResetPinOut = pinOut_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_leaveReset;
        (state_q == SOS_RESET) && !resetReq;
    endsequence

    sequence s_coldThenWarm;
        (state_q == SOS_COLD) ##1 (state_q == SOS_WARM) && cpuResetN_q;
    endsequence

    sequence s_pinRelease;
        $rose(pinSync) && (state_q == SOS_RESET) && !faultCpuRst;
    endsequence

    sequence s_safeEntry;
        $rose(state_q == SOS_SAFE);
    endsequence

    a_reset_entry: assert property (resetReq |=> state_q == SOS_RESET)
        else $error("reset request did not reach reset state");

    a_cold_holds_cpu: assert property (state_q == SOS_COLD |-> !cpuResetN_q && coldInit_q)
        else $error("CPU not held in reset during cold boot");

    a_cold_release: assert property
        ((state_q == SOS_COLD) && coldDone && !resetReq |-> s_coldThenWarm)
        else $error("cold boot end did not release CPU");

    a_rom_fetch: assert property (state_q == SOS_WARM |-> bootFromRom_q)
        else $error("warm boot not fetching from ROM");

    a_secure_start: assert property ($rose(state_q == SOS_WARM) |-> memSecure_q)
        else $error("memories not secure at warm boot start");

    a_preop_order: assert property ($rose(state_q == SOS_OPER) |-> $past(state_q) == SOS_PREOP)
        else $error("operational entered without pre-operational");

    a_warm_pulse: assert property ($rose(pinOe_q) |-> pinOe_q [*3])
        else $error("warm reset pulse too short");

    a_irq_path: assert property (faultIrq |=> cpuIrq_q)
        else $error("interrupt fault not signalled");

    a_nmi_escalate: assert property (nmiDone |=> pinOe_q ##[1:4] !pinSync || !pinOe_q)
        else $error("unserviced NMI did not drive warm reset pin");

    a_cold_restart: assert property (s_leaveReset |=> state_q == SOS_COLD)
        else $error("reset release did not restart cold boot");

    a_err_on_fault: assert property (faultNmi |=> errStatus_q && cpuNmi_q)
        else $error("Level 2 fault not shown on error status");

    a_actuator_off: assert property (errStatus_q || state_q != SOS_OPER |-> actOff_q)
        else $error("actuator outputs not forced inactive");

    a_power_hold: assert property (faultPowerDown |=> powerDownReq [*2])
        else $error("power-down request not held");

    a_err_sticky: assert property (errStatus_q && !errClear |=> errStatus_q)
        else $error("error status dropped without clear");

    a_cold_init_only: assert property (coldInit_q |-> state_q == SOS_COLD)
        else $error("cold init strobe outside cold boot");

    a_reset_holds_cpu: assert property (state_q == SOS_RESET |-> !cpuResetN_q)
        else $error("CPU out of reset in reset state");

    a_cpu_run_late: assert property
        (cpuResetN_q |-> state_q != SOS_RESET && state_q != SOS_COLD)
        else $error("CPU released before cold boot end");

    a_rom_only_warm: assert property (bootFromRom_q |-> state_q == SOS_WARM)
        else $error("boot ROM fetch outside warm boot");

    a_secure_boot: assert property
        (state_q == SOS_RESET || state_q == SOS_COLD |-> memSecure_q)
        else $error("memories not secure before warm boot");

    a_relax_in_warm: assert property
        ($fell(memSecure_q) |-> $past(state_q) == SOS_WARM && $past(secRelax))
        else $error("security loosened outside warm boot");

    a_preop_entry: assert property
        ($rose(state_q == SOS_PREOP) |-> $past(state_q) == SOS_WARM && $past(bootDone))
        else $error("pre-operational entered without boot hand-over");

    a_oper_entry: assert property
        ($rose(state_q == SOS_OPER) |-> $past(selfTestPass && !selfTestFail))
        else $error("operational entered without self-test pass");

    a_irq_clear: assert property (!faultIrq |=> !cpuIrq_q)
        else $error("interrupt raised without fault");

    a_nmi_hold: assert property
        (cpuNmi_q && !nmiAck && state_q != SOS_RESET |=> cpuNmi_q)
        else $error("pending NMI dropped without ack");

    a_nmi_ack: assert property (nmiAck && !faultNmi |=> !cpuNmi_q)
        else $error("NMI ack did not clear pending NMI");

    a_nmi_reset: assert property (state_q == SOS_RESET && !faultNmi |=> !cpuNmi_q)
        else $error("pending NMI survived CPU reset");

    a_pin_cause: assert property
        ($rose(pinOe_q) |-> $past(faultWarmRst || nmiDone))
        else $error("warm reset pin driven without cause");

    a_pin_release: assert property ($fell(pinOe_q) |-> $past(pulseDone))
        else $error("warm reset pulse cut short");

    a_warm_restart: assert property (s_pinRelease |=> state_q == SOS_COLD)
        else $error("pin release did not restart cold boot");

    a_safe_entry: assert property (s_safeEntry |-> errStatus_q)
        else $error("safe state entered without error status");

    a_safe_stays: assert property
        (state_q == SOS_SAFE && !resetReq |=> state_q == SOS_SAFE)
        else $error("safe state left without reset");

    a_act_in_oper: assert property
        (state_q == SOS_OPER && !errStatus_q |-> !actOff_q)
        else $error("actuator outputs held off in clean operation");

    a_power_sticky: assert property (powerDownReq |=> powerDownReq)
        else $error("power-down request withdrawn");

    a_err_clear: assert property
        (errClear && !faultNmi && !selfTestFail |=> !errStatus_q)
        else $error("error status not cleared by software");

endmodule

// ==== sim/sos_supervisor_model.sv ====
/*
 * Far-side model: external supervisor, voltage monitor and watchdog.
 * Assumes the bench drives tbRst_b and extPull on clk; the warm reset
 * pin is open drain with a pull-up on the board.
 */
`timescale 1ns/1ps
module sos_supervisor_model #(
    parameter int OFF_CYC = 6,
    parameter int WD_LIM = 1000
) (
    input wire logic clk, // System clock
    input wire logic tbRst_b, // Bench power-on reset, active low
    input wire logic pinOe, // Device pulls the warm reset pin
    input wire logic pinOut, // Value the device drives
    input wire logic extPull, // External monitor pulls the pin low
    input wire logic powerDownReq, // Device asks for power removal
    input wire logic errorStatusOut, // Device error-status pin
    output logic pinLevel, // Resolved level of the warm reset pin
    output logic rst_b // Reset seen by the device, active low
);
    logic [7:0] offCnt_q;
    logic [15:0] errCnt_q;
    logic powerOn;
    logic wdExpired;

    // ****************************************
    // Pin and power resolution
    // ****************************************
    // Pull-up wins unless someone pulls low
    assign pinLevel = ((pinOe && pinOut == 1'b0) || extPull) ? 1'b0 : 1'b1;
    assign powerOn = (offCnt_q == 8'h00);
    assign rst_b = tbRst_b & powerOn;
    assign wdExpired = (errCnt_q >= 16'(WD_LIM));

    // Removes power on request or watchdog expiry, in any state
    always_ff @(posedge clk or negedge tbRst_b) begin
        if (!tbRst_b) begin
            offCnt_q <= 8'h00;
        end else if (powerOn && (powerDownReq || wdExpired)) begin
            offCnt_q <= 8'(OFF_CYC);
        end else if (!powerOn) begin
            offCnt_q <= offCnt_q - 8'h01;
        end
    end

    // Watchdog: error status left standing too long
    always_ff @(posedge clk or negedge tbRst_b) begin
        if (!tbRst_b) begin
            errCnt_q <= 16'h0000;
        end else if (!powerOn || !errorStatusOut) begin
            errCnt_q <= 16'h0000;
        end else begin
            errCnt_q <= errCnt_q + 16'h0001;
        end
    end
endmodule

// ==== sim/sos_sequencer_tb_top.sv ====
/*
 * Self-checking bench of the operating-state sequencer with its far side.
 * Assumes sos_pkg and the supervisor model are compiled first.
 */
`timescale 1ns/1ps
module sos_sequencer_tb_top;
    import sos_pkg::*;
    localparam int CC = 8;
    localparam int PC = 6;
    localparam int NW = 20;
    localparam int IRQ = 0, NMI = 1, CRST = 2, WRST = 3, PDN = 4, ACK = 5, CLR = 6;
    localparam int SEC = 7, BDONE = 8, PASS = 9, FAIL = 10;
    logic clk = 1'b0;
    logic tbRst_b = 1'b0;
    logic extPull = 1'b0;
    logic [10:0] req = 11'h000;
    logic rst_b, pinLevel, warmResetPinOut, warmResetPinOe, cpuResetN, coldInit;
    logic bootFromRom, memSecure, cpuIrq, cpuNmi, errorStatusOut, actuatorOff, powerDownReq;
    logic prev;
    sos_state_t opState;
    int mismatches = 0;
    int nChecks = 0;
    int cycles = 0;
    int n;

    always #10 clk = ~clk;

    sos_supervisor_model sos_supervisor_model_inst (.clk(clk), .tbRst_b(tbRst_b),
        .pinOe(warmResetPinOe), .pinOut(warmResetPinOut), .extPull(extPull),
        .powerDownReq(powerDownReq), .errorStatusOut(errorStatusOut),
        .pinLevel(pinLevel), .rst_b(rst_b));

    sos_sequencer #(.NMI_WAIT_CYC(NW), .COLD_CYC(CC), .PULSE_CYC(PC)) sos_sequencer_inst (
        .clk(clk), .rst_b(rst_b), .warmResetPinIn(pinLevel),
        .warmResetPinOut(warmResetPinOut), .warmResetPinOe(warmResetPinOe),
        .faultIrq(req[IRQ]), .faultNmi(req[NMI]), .faultCpuRst(req[CRST]),
        .faultWarmRst(req[WRST]), .faultPowerDown(req[PDN]), .nmiAck(req[ACK]),
        .errClear(req[CLR]), .secRelax(req[SEC]), .bootDone(req[BDONE]),
        .selfTestPass(req[PASS]), .selfTestFail(req[FAIL]), .opState(opState),
        .cpuResetN(cpuResetN), .coldInit(coldInit), .bootFromRom(bootFromRom),
        .memSecure(memSecure), .cpuIrq(cpuIrq), .cpuNmi(cpuNmi),
        .errorStatusOut(errorStatusOut), .actuatorOff(actuatorOff),
        .powerDownReq(powerDownReq));

    // ****************************************
    // Compare and drive tasks
    // ****************************************
    // Actuators stay off unless operational with no error latched
    function automatic logic expActOff(input logic oper, input logic err);
        return !oper || err;
    endfunction

    task automatic chkBit(input string what, input logic exp, input logic got);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chkState(input sos_state_t exp);
        nChecks++;
        if (opState !== exp) begin
            mismatches++;
            $display("Error opState expected %b seen %b", exp, opState);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // One-cycle request, outputs settled after the sampling edge
    task automatic pulse(input int i);
        @(posedge clk);
        req[i] <= 1'b1;
        @(posedge clk);
        req[i] <= 1'b0;
        #1;
    endtask

    task automatic waitState(input sos_state_t s, input int lim);
        int k;
        k = 0;
        while (opState !== s && k < lim) begin
            step(1);
            k++;
        end
        chkState(s);
    endtask

    // Cold boot to OPER, or to SAFE through a failed self-test
    task automatic bootTo(input logic toOper);
        int k;
        waitState(SOS_COLD, 12);
        chkBit("cpuResetN", 1'b0, cpuResetN);
        k = 0;
        while (opState === SOS_COLD && k < 100) begin
            if (k == 1) chkBit("coldInit", 1'b1, coldInit);
            step(1);
            k++;
        end
        chkBit("coldLength", 1'b1, k == CC);
        chkState(SOS_WARM);
        chkBit("cpuResetN", 1'b1, cpuResetN);
        chkBit("bootFromRom", 1'b1, bootFromRom);
        chkBit("memSecure", 1'b1, memSecure);
        pulse(PASS);
        chkState(SOS_WARM);
        pulse(SEC);
        chkBit("memSecure", 1'b0, memSecure);
        pulse(BDONE);
        waitState(SOS_PREOP, 3);
        chkBit("bootFromRom", 1'b0, bootFromRom);
        pulse(toOper ? PASS : FAIL);
        waitState(toOper ? SOS_OPER : SOS_SAFE, 3);
        step(1);
        chkBit("actuatorOff", expActOff(toOper, !toOper), actuatorOff);
        if (!toOper) chkBit("errorStatus", 1'b1, errorStatusOut);
    endtask

    // Warm reset pin pulse: length, and reset state while it stands
    task automatic pinPulse;
        logic seen;
        int k;
        seen = 1'b0;
        k = 0;
        while (warmResetPinOe === 1'b1 && k < 100) begin
            seen = seen | (opState === SOS_RESET);
            if (k == 0) chkBit("pinOut", 1'b0, warmResetPinOut);
            step(1);
            k++;
        end
        chkBit("pulseLen", 1'b1, k == PC);
        chkBit("warmToReset", 1'b1, seen | (opState === SOS_RESET));
    endtask

    task automatic endOfTest;
        if (mismatches == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            endOfTest();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(57473));
        step(10);
        chkState(SOS_RESET);
        chkBit("cpuResetN", 1'b0, cpuResetN);
        chkBit("actuatorOff", 1'b1, actuatorOff);
        @(posedge clk);
        tbRst_b <= 1'b1;
        bootTo(1'b1);
        // Random interrupt requests echoed one cycle later
        repeat (24) begin
            @(posedge clk);
            prev = req[IRQ];
            req[IRQ] <= 1'($urandom);
            #1;
            chkBit("cpuIrq", prev, cpuIrq);
        end
        @(posedge clk);
        req[IRQ] <= 1'b0;
        step(2);
        chkState(SOS_OPER);
        // Serviced NMI: error sticks until cleared, no escalation
        pulse(NMI);
        chkBit("cpuNmi", 1'b1, cpuNmi);
        chkBit("errorStatus", 1'b1, errorStatusOut);
        waitState(SOS_SAFE, 3);
        chkBit("actuatorOff", 1'b1, actuatorOff);
        step(2 + $urandom_range(8));
        chkBit("errorSticky", 1'b1, errorStatusOut);
        pulse(ACK);
        chkBit("cpuNmi", 1'b0, cpuNmi);
        pulse(CLR);
        chkBit("errorStatus", 1'b0, errorStatusOut);
        step(NW + 5);
        chkBit("pinOe", 1'b0, warmResetPinOe);
        chkState(SOS_SAFE);
        // Unserviced NMI escalates to the warm reset pin
        pulse(NMI);
        n = 0;
        while (warmResetPinOe !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        chkBit("nmiWait", 1'b1, n >= NW - 2 && n <= NW + 2);
        pinPulse();
        bootTo(1'b0);
        chkBit("cpuNmi", 1'b0, cpuNmi);
        // Error left standing: watchdog removes power
        waitState(SOS_RESET, 1100);
        chkBit("errorStatus", 1'b0, errorStatusOut);
        bootTo(1'b1);
        // CPU reset fault
        pulse(CRST);
        waitState(SOS_RESET, 2);
        chkBit("cpuResetN", 1'b0, cpuResetN);
        bootTo(1'b1);
        // Warm reset fault
        pulse(WRST);
        chkBit("pinOe", 1'b1, warmResetPinOe);
        pinPulse();
        bootTo(1'b1);
        // External monitor pulls the pin
        @(posedge clk);
        extPull <= 1'b1;
        waitState(SOS_RESET, 4);
        @(posedge clk);
        extPull <= 1'b0;
        bootTo(1'b1);
        // Power-down request, then recovery through cold boot
        pulse(PDN);
        chkBit("powerDownReq", 1'b1, powerDownReq);
        waitState(SOS_RESET, 8);
        chkBit("powerDownReq", 1'b0, powerDownReq);
        bootTo(1'b1);
        endOfTest();
    end
endmodule
